// ---- inc/qhrp_map.svh ----
// Constants for the quad serial host port: widths, pin positions, reset values, timing
`ifndef QHRP_MAP_SVH
`define QHRP_MAP_SVH

// Bus widths and channel count
`define QHRP_ADDR_W        3
`define QHRP_DATA_W        8
`define QHRP_NUM_CHAN      4
`define QHRP_CHAN_W        2
`define QHRP_REGS_PER_CHAN 8

// Levels of the mode pin and of the direction pin
`define QHRP_MODE_SEPARATE 1'b1
`define QHRP_MODE_DIRSEL   1'b0
`define QHRP_DIR_READ      1'b1
`define QHRP_DIR_WRITE     1'b0

// Idle level of the data wires and register reset value
`define QHRP_PULLUP_BYTE   8'hFF
`define QHRP_REG_RST       8'h00

// Bit positions inside the device's pin sampling vector
`define QHRP_SYNC_W        18
`define QHRP_SB_DATA       0
`define QHRP_SB_ADDR       8
`define QHRP_SB_RD         11
`define QHRP_SB_WR         12
`define QHRP_SB_CS         13
`define QHRP_SB_MODE       17
`define QHRP_SYNC_RST      18'h3F800

// Host-side phase lengths in clock cycles
`define QHRP_SETUP_CYC     2
`define QHRP_STROBE_CYC    12
`define QHRP_HOLD_CYC      2
`define QHRP_GAP_CYC       2
`define QHRP_CNT_W         8

`endif

// ---- inc/qhrp_pkg.sv ----
// Types shared by both ends of the quad serial host port
`default_nettype none
`include "qhrp_map.svh"

package qhrp_pkg;
    typedef logic [`QHRP_DATA_W-1:0] qhrp_byte_t;
    typedef logic [`QHRP_ADDR_W-1:0] qhrp_addr_t;
    typedef logic [`QHRP_CHAN_W-1:0] qhrp_chan_t;
    typedef enum {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD, HS_GAP} qhrp_host_state_t;
endpackage

`default_nettype wire

// ---- inc/qhrp_if.sv ----
// Pin bundle between host processor and the quad serial device
`timescale 1ns/1ps
`default_nettype none
`include "qhrp_map.svh"

interface qhrp_if;
    logic                    bus_mode;
    logic [`QHRP_ADDR_W-1:0] addr;
    logic                    read_strobe_n;
    logic                    write_strobe_n;
    logic                    chan_a_select_n;
    logic                    chan_b_select_n;
    logic                    chan_c_select_n;
    logic                    chan_d_select_n;
    logic [`QHRP_DATA_W-1:0] host_data;
    logic                    host_data_oe;
    logic [`QHRP_DATA_W-1:0] dev_data;
    logic                    dev_data_oe;
    logic [`QHRP_DATA_W-1:0] data_bus;

    // Resolved level of the shared data wires, pulled up when idle
    assign data_bus = dev_data_oe  ? dev_data  :
                      host_data_oe ? host_data : `QHRP_PULLUP_BYTE;

    modport dev (
        input  bus_mode, addr, read_strobe_n, write_strobe_n,
        input  chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
        input  data_bus,
        output dev_data, dev_data_oe
    );

    modport host (
        output bus_mode, addr, read_strobe_n, write_strobe_n,
        output chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
        output host_data, host_data_oe,
        input  data_bus
    );
endinterface

`default_nettype wire

// ---- design/qhrp_device.sv ----
// Device end of the quad serial host port: pin sampling, register file, read drive
//
// Overview of operation
// RULE_01: Three address lines pick selected channel register.
// RULE_02: Eight-bit shared data bus, device drives reads.
// RULE_03: Mode high: read pin is active-low strobe.
// RULE_04: Read strobe fall fetches addressed register byte.
// RULE_05: Byte held on bus while strobe low.
// RULE_06: Mode low: read pin ignored, tied high.
// RULE_07: Mode high: each select enables one channel.
// RULE_08: Write strobe fall starts, rise commits byte.
// RULE_09: Mode low: write pin gives direction.
// RULE_10: Drivers off unless selected read in progress.
`timescale 1ns/1ps
`default_nettype none
`include "qhrp_map.svh"

module qhrp_device
    import qhrp_pkg::*;
#(
    parameter int NUM_CHAN = `QHRP_NUM_CHAN
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    qhrp_if.dev                          bus_if,
    input  wire logic                    loc_we_in,
    input  wire logic [`QHRP_CHAN_W-1:0] loc_chan_in,
    input  wire logic [`QHRP_ADDR_W-1:0] loc_addr_in,
    input  wire logic [`QHRP_DATA_W-1:0] loc_wdata_in,
    output logic                         host_rd_out,
    output logic                         host_wr_out,
    output logic [`QHRP_CHAN_W-1:0]      acc_chan_out,
    output logic [`QHRP_ADDR_W-1:0]      acc_addr_out,
    output logic [`QHRP_DATA_W-1:0]      acc_data_out
);

    localparam int NUM_REGS = NUM_CHAN * `QHRP_REGS_PER_CHAN;
    localparam logic [`QHRP_SYNC_W-1:0] SYNC_IDLE = `QHRP_SYNC_RST;

    // Decodes the selects into {valid, channel} for the current bus style
    function automatic logic [`QHRP_CHAN_W:0] chan_decode(
        input logic       mode,
        input logic [3:0] cs_n
    );
        logic [`QHRP_CHAN_W:0] res;
        res = '0;
        if (mode == `QHRP_MODE_SEPARATE) begin
            // One active-low select per channel, A has priority
            if (!cs_n[0]) begin
                res = {1'b1, 2'h0};                         // [RULE_07]
            end else if (!cs_n[1]) begin
                res = {1'b1, 2'h1};                         // [RULE_07]
            end else if (!cs_n[2]) begin
                res = {1'b1, 2'h2};                         // [RULE_07]
            end else if (!cs_n[3]) begin
                res = {1'b1, 2'h3};                         // [RULE_07]
            end
        end else begin
            // Single select on A, channel from the B and C select pins
            res = {~cs_n[0], cs_n[2], cs_n[1]};
        end
        return res;
    endfunction

    // Pin sampling stages
    logic [`QHRP_SYNC_W-1:0] sync1;
    logic [`QHRP_SYNC_W-1:0] sync2;
    logic [`QHRP_SYNC_W-1:0] sync3;
    logic [`QHRP_SYNC_W-1:0] filt;
    logic [`QHRP_SYNC_W-1:0] raw_pins;

    // Decoded filtered pins
    logic                    mode;
    logic                    rd_n;
    logic                    wr_n;
    logic [3:0]              cs_n;
    qhrp_addr_t              pin_addr;
    qhrp_byte_t              pin_data;
    logic [`QHRP_CHAN_W:0]   sel;

    // Access tracking
    logic                    rd_active;
    logic                    wr_active;
    logic                    rd_active_d;
    logic                    wr_active_d;
    logic                    rd_start;
    logic                    wr_start;
    logic                    wr_end;
    qhrp_chan_t              wr_chan;
    qhrp_addr_t              wr_addr;
    qhrp_byte_t              wr_data;

    // Register storage and read drive
    qhrp_byte_t              regs [NUM_REGS];
    qhrp_byte_t              dout;
    logic                    dout_oe;

    // Gather every pin into one vector for sampling
    assign raw_pins = {bus_if.bus_mode,
                       bus_if.chan_d_select_n, bus_if.chan_c_select_n,
                       bus_if.chan_b_select_n, bus_if.chan_a_select_n,
                       bus_if.write_strobe_n, bus_if.read_strobe_n,
                       bus_if.addr, bus_if.data_bus};

    // Three-stage sampler for all pins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1 <= `QHRP_SYNC_RST;
            sync2 <= `QHRP_SYNC_RST;
            sync3 <= `QHRP_SYNC_RST;
        end else begin
            sync1 <= raw_pins;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Per-bit filter: a change counts once stages two and three agree
    generate
        for (genvar i = 0; i < `QHRP_SYNC_W; i++) begin : g_filt
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    filt[i] <= SYNC_IDLE[i];
                end else if (sync2[i] == sync3[i]) begin
                    filt[i] <= sync3[i];
                end
            end
        end
    endgenerate

    // Field split of the filtered pins
    assign mode     = filt[`QHRP_SB_MODE];
    assign rd_n     = filt[`QHRP_SB_RD];
    assign wr_n     = filt[`QHRP_SB_WR];
    assign cs_n     = filt[`QHRP_SB_CS +: 4];
    assign pin_addr = filt[`QHRP_SB_ADDR +: `QHRP_ADDR_W];            // [RULE_01]
    assign pin_data = filt[`QHRP_SB_DATA +: `QHRP_DATA_W];            // [RULE_02]
    assign sel      = chan_decode(mode, cs_n);

    // Read access: strobe pin in separate style, direction pin otherwise
    always_comb begin
        if (mode == `QHRP_MODE_SEPARATE) begin
            rd_active = sel[`QHRP_CHAN_W] & ~rd_n;                    // [RULE_03]
        end else begin
            rd_active = sel[`QHRP_CHAN_W] & (wr_n == `QHRP_DIR_READ); // [RULE_06] [RULE_09]
        end
    end

    // Write access: low write pin means strobe or write direction alike
    assign wr_active = sel[`QHRP_CHAN_W] & ~wr_n;                     // [RULE_08] [RULE_09]

    // Edge detection on the access levels
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_active_d <= 1'b0;
            wr_active_d <= 1'b0;
        end else begin
            rd_active_d <= rd_active;
            wr_active_d <= wr_active;
        end
    end

    assign rd_start = rd_active & ~rd_active_d;                       // [RULE_04]
    assign wr_start = wr_active & ~wr_active_d;                       // [RULE_08]
    assign wr_end   = ~wr_active & wr_active_d;                       // [RULE_08]

    // Write target latched at the start, data tracked while active
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_chan <= '0;
            wr_addr <= '0;
            wr_data <= `QHRP_REG_RST;
        end else begin
            if (wr_start) begin
                wr_chan <= sel[`QHRP_CHAN_W-1:0];                     // [RULE_01]
                wr_addr <= pin_addr;                                  // [RULE_01]
            end
            if (wr_active) begin
                wr_data <= pin_data;                                  // [RULE_02]
            end
        end
    end

    // Register file: host commit wins over a local write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                regs[r] <= `QHRP_REG_RST;
            end
        end else if (wr_end) begin
            regs[{wr_chan, wr_addr}] <= wr_data;                      // [RULE_08]
        end else if (loc_we_in) begin
            regs[{loc_chan_in, loc_addr_in}] <= loc_wdata_in;
        end
    end

    // Read fetch and bus drive
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dout    <= `QHRP_REG_RST;
            dout_oe <= 1'b0;
        end else if (rd_start) begin
            dout    <= regs[{sel[`QHRP_CHAN_W-1:0], pin_addr}];      // [RULE_04]
            dout_oe <= 1'b1;                                          // [RULE_05]
        end else if (!rd_active) begin
            dout_oe <= 1'b0;                                          // [RULE_10]
        end
    end

    assign bus_if.dev_data    = dout;                                 // [RULE_02]
    assign bus_if.dev_data_oe = dout_oe;                              // [RULE_05] [RULE_10]

    // Access report towards the channel logic
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            host_rd_out  <= 1'b0;
            host_wr_out  <= 1'b0;
            acc_chan_out <= '0;
            acc_addr_out <= '0;
            acc_data_out <= `QHRP_REG_RST;
        end else begin
            host_rd_out <= rd_start;
            host_wr_out <= wr_end;
            if (rd_start) begin
                acc_chan_out <= sel[`QHRP_CHAN_W-1:0];
                acc_addr_out <= pin_addr;
                acc_data_out <= regs[{sel[`QHRP_CHAN_W-1:0], pin_addr}];
            end else if (wr_end) begin
                acc_chan_out <= wr_chan;
                acc_addr_out <= wr_addr;
                acc_data_out <= wr_data;
            end
        end
    end

endmodule

`default_nettype wire

// ---- design/qhrp_host.sv ----
// Host end of the quad serial host port: timed register reads and writes
`timescale 1ns/1ps
`default_nettype none
`include "qhrp_map.svh"

module qhrp_host
    import qhrp_pkg::*;
#(
    parameter int SETUP_CYC  = `QHRP_SETUP_CYC,
    parameter int STROBE_CYC = `QHRP_STROBE_CYC,
    parameter int HOLD_CYC   = `QHRP_HOLD_CYC,
    parameter int GAP_CYC    = `QHRP_GAP_CYC
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    qhrp_if.host                         bus_if,
    input  wire logic                    mode_in,
    input  wire logic                    req_valid_in,
    input  wire logic                    req_write_in,
    input  wire logic [`QHRP_CHAN_W-1:0] req_chan_in,
    input  wire logic [`QHRP_ADDR_W-1:0] req_addr_in,
    input  wire logic [`QHRP_DATA_W-1:0] req_wdata_in,
    output logic                         req_ready_out,
    output logic                         done_out,
    output logic [`QHRP_DATA_W-1:0]      rdata_out
);

    qhrp_host_state_t         state;
    logic [`QHRP_CNT_W-1:0]   cnt;
    logic                     mode;
    logic                     is_write;
    qhrp_chan_t               chan;
    qhrp_addr_t               addr;
    qhrp_byte_t               wdata;
    qhrp_byte_t               dsync1;
    qhrp_byte_t               dsync2;
    qhrp_byte_t               dsync3;
    qhrp_byte_t               dfilt;
    logic                     cnt_done;
    logic                     in_access;
    logic                     strobing;

    assign req_ready_out = (state == HS_IDLE);
    assign cnt_done      = (cnt == '0);
    assign in_access     = (state == HS_SETUP) || (state == HS_STROBE) || (state == HS_HOLD);
    assign strobing      = (state == HS_STROBE);

    // Phase sequencer; request fields latched on acceptance, mode tracked while idle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state    <= HS_IDLE;
            cnt      <= '0;
            mode     <= `QHRP_MODE_SEPARATE;
            is_write <= 1'b0;
            chan     <= '0;
            addr     <= '0;
            wdata    <= `QHRP_REG_RST;
        end else begin
            case (state)
                HS_IDLE: begin
                    mode <= mode_in;
                    if (req_valid_in) begin
                        is_write <= req_write_in;
                        chan     <= req_chan_in;
                        addr     <= req_addr_in;
                        wdata    <= req_wdata_in;
                        cnt      <= `QHRP_CNT_W'(SETUP_CYC - 1);
                        state    <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_done) begin
                        cnt   <= `QHRP_CNT_W'(STROBE_CYC - 1);
                        state <= HS_STROBE;
                    end
                end
                HS_STROBE: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_done) begin
                        cnt   <= `QHRP_CNT_W'(HOLD_CYC - 1);
                        state <= HS_HOLD;
                    end
                end
                HS_HOLD: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_done) begin
                        cnt   <= `QHRP_CNT_W'(GAP_CYC - 1);
                        state <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    cnt <= cnt - 1'b1;
                    if (cnt_done) begin
                        state <= HS_IDLE;
                    end
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    // Pin drive per bus style
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bus_if.bus_mode        <= `QHRP_MODE_SEPARATE;
            bus_if.addr            <= '0;
            bus_if.read_strobe_n   <= 1'b1;
            bus_if.write_strobe_n  <= 1'b1;
            bus_if.chan_a_select_n <= 1'b1;
            bus_if.chan_b_select_n <= 1'b1;
            bus_if.chan_c_select_n <= 1'b1;
            bus_if.chan_d_select_n <= 1'b1;
            bus_if.host_data       <= `QHRP_REG_RST;
            bus_if.host_data_oe    <= 1'b0;
        end else begin
            bus_if.bus_mode     <= mode;
            bus_if.addr         <= addr;                              // [RULE_01]
            bus_if.host_data    <= wdata;                             // [RULE_02]
            bus_if.host_data_oe <= in_access & is_write;              // [RULE_02]
            if (mode == `QHRP_MODE_SEPARATE) begin
                bus_if.read_strobe_n   <= ~(strobing & ~is_write);    // [RULE_05]
                bus_if.write_strobe_n  <= ~(strobing & is_write);     // [RULE_08]
                bus_if.chan_a_select_n <= ~(in_access && chan == 2'h0);
                bus_if.chan_b_select_n <= ~(in_access && chan == 2'h1);
                bus_if.chan_c_select_n <= ~(in_access && chan == 2'h2);
                bus_if.chan_d_select_n <= ~(in_access && chan == 2'h3);
            end else begin
                bus_if.read_strobe_n   <= 1'b1;                       // [RULE_06]
                bus_if.write_strobe_n  <= is_write ? `QHRP_DIR_WRITE
                                                   : `QHRP_DIR_READ;  // [RULE_09]
                bus_if.chan_a_select_n <= ~strobing;
                bus_if.chan_b_select_n <= chan[0];
                bus_if.chan_c_select_n <= chan[1];
                bus_if.chan_d_select_n <= 1'b1;
            end
        end
    end

    // Data wires sampled through three stages, filtered per bit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dsync1 <= `QHRP_PULLUP_BYTE;
            dsync2 <= `QHRP_PULLUP_BYTE;
            dsync3 <= `QHRP_PULLUP_BYTE;
            dfilt  <= `QHRP_PULLUP_BYTE;
        end else begin
            dsync1 <= bus_if.data_bus;
            dsync2 <= dsync1;
            dsync3 <= dsync2;
            dfilt  <= (~(dsync2 ^ dsync3) & dsync3) | ((dsync2 ^ dsync3) & dfilt);
        end
    end

    // Read byte taken on the last strobe cycle, one clock before the strobe pin rises
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= `QHRP_REG_RST;
            done_out  <= 1'b0;
        end else begin
            done_out <= (state == HS_STROBE) && cnt_done;
            if ((state == HS_STROBE) && cnt_done && !is_write) begin
                rdata_out <= dfilt;                                   // [RULE_05]
            end
        end
    end

endmodule

`default_nettype wire

// ---- sim/qhrp_checker.sv ----
// Pin-level assertions on the host port between both ends
`timescale 1ns/1ps
`default_nettype none

module qhrp_checker (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       bus_mode,
    input  wire logic [2:0] addr,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic       chan_a_select_n,
    input  wire logic       chan_b_select_n,
    input  wire logic       chan_c_select_n,
    input  wire logic       chan_d_select_n,
    input  wire logic [7:0] host_data,
    input  wire logic       host_data_oe,
    input  wire logic [7:0] dev_data,
    input  wire logic       dev_data_oe
);
    logic       any_sel;
    logic       rd_act;
    logic       wr_act;
    logic [3:0] idle_cnt;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Read or write access on the pins in either bus style
    assign any_sel = !(chan_a_select_n && chan_b_select_n && chan_c_select_n && chan_d_select_n);
    assign rd_act = bus_mode ? (!read_strobe_n && any_sel) : (!chan_a_select_n && write_strobe_n);
    assign wr_act = bus_mode ? !write_strobe_n : (!chan_a_select_n && !write_strobe_n);

    // Cycles since the last read access, saturating
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            idle_cnt <= 4'hF;
        end else if (rd_act) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hF) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end

    a_no_contention: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive the data wires");
    a_drive_only_read: assert property (dev_data_oe |-> idle_cnt <= 4'hA)
        else $error("device drives data outside a read");
    a_byte_by_strobe: assert property (rd_act [*8] |-> dev_data_oe)
        else $error("no byte on the bus during a long read");
    a_byte_steady: assert property (dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data))
        else $error("read byte changed while driven");
    a_addr_steady: assert property ((rd_act || wr_act) && $past(rd_act || wr_act) |-> $stable(addr))
        else $error("address moved during an access");
    a_wdata_steady: assert property (wr_act && $past(wr_act) |-> host_data_oe && $stable(host_data))
        else $error("write byte not held by host");
    a_style0_pins_idle: assert property (!bus_mode |-> read_strobe_n && chan_d_select_n)
        else $error("unused pins not high in direction style");
    a_host_off_read: assert property (rd_act |-> !host_data_oe)
        else $error("host drives data during a read");

    c_read_sep: cover property (bus_mode && rd_act ##1 dev_data_oe);
    c_read_dir: cover property (!bus_mode && rd_act && dev_data_oe);
    c_write: cover property (wr_act ##1 !wr_act);
endmodule

`default_nettype wire

// ---- sim/quad_uart_host_read_port_test.sv ----
// Bench joining host end and device end of the port
`timescale 1ns/1ps
`default_nettype none

module quad_uart_host_read_port_test;
    import qhrp_pkg::*;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       mode = 1'b1;
    logic       req_valid = 1'b0;
    logic       req_write = 1'b0;
    qhrp_chan_t req_chan = 2'h0;
    qhrp_addr_t req_addr = 3'h0;
    qhrp_byte_t req_wdata = 8'h00;
    logic       req_ready;
    logic       done;
    qhrp_byte_t rdata;
    logic       loc_we = 1'b0;
    qhrp_chan_t loc_chan = 2'h0;
    qhrp_addr_t loc_addr = 3'h0;
    qhrp_byte_t loc_wdata = 8'h00;
    logic       host_rd;
    logic       host_wr;
    qhrp_chan_t acc_chan;
    qhrp_addr_t acc_addr;
    qhrp_byte_t acc_data;
    int         fail_count = 0;
    int         compares = 0;
    int         cycles = 0;
    int         rd_seen = 0;
    int         wr_seen = 0;

    qhrp_if bus ();

    qhrp_host qhrp_host_i (.clk_in(clk_in), .rst_in(rst_in), .bus_if(bus), .mode_in(mode),
        .req_valid_in(req_valid), .req_write_in(req_write), .req_chan_in(req_chan),
        .req_addr_in(req_addr), .req_wdata_in(req_wdata), .req_ready_out(req_ready),
        .done_out(done), .rdata_out(rdata));

    qhrp_device qhrp_device_i (.clk_in(clk_in), .rst_in(rst_in), .bus_if(bus),
        .loc_we_in(loc_we), .loc_chan_in(loc_chan), .loc_addr_in(loc_addr),
        .loc_wdata_in(loc_wdata), .host_rd_out(host_rd), .host_wr_out(host_wr),
        .acc_chan_out(acc_chan), .acc_addr_out(acc_addr), .acc_data_out(acc_data));

    qhrp_checker qhrp_checker_i (.clk_in(clk_in), .rst_in(rst_in), .bus_mode(bus.bus_mode),
        .addr(bus.addr), .read_strobe_n(bus.read_strobe_n),
        .write_strobe_n(bus.write_strobe_n), .chan_a_select_n(bus.chan_a_select_n),
        .chan_b_select_n(bus.chan_b_select_n), .chan_c_select_n(bus.chan_c_select_n),
        .chan_d_select_n(bus.chan_d_select_n), .host_data(bus.host_data),
        .host_data_oe(bus.host_data_oe), .dev_data(bus.dev_data),
        .dev_data_oe(bus.dev_data_oe));

    // Verdict and end of run
    task automatic report_and_stop();
        $display("Counts: %0d mismatches in %0d compares", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input qhrp_byte_t exp, input qhrp_byte_t seen);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One host request, waits for its completion pulse
    task automatic access(input logic wr, input qhrp_chan_t ch, input qhrp_addr_t ad,
                          input qhrp_byte_t wd);
        int n;
        n = 0;
        @(negedge clk_in);
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        req_valid = 1'b1;
        req_write = wr;
        req_chan = ch;
        req_addr = ad;
        req_wdata = wd;
        @(negedge clk_in);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        chk("done", 8'h01, {7'h00, done});
    endtask

    task automatic rd(input qhrp_chan_t ch, input qhrp_addr_t ad, input qhrp_byte_t exp);
        access(1'b0, ch, ad, 8'h00);
        chk("rdata", exp, rdata);
        chk("acc_chan", {6'h00, ch}, {6'h00, acc_chan});
        chk("acc_addr", {5'h00, ad}, {5'h00, acc_addr});
        chk("acc_data", exp, acc_data);
    endtask

    // Distinct byte per register and per writing style
    function automatic qhrp_byte_t pat(input logic m, input qhrp_chan_t c, input qhrp_addr_t a);
        return {c, a, 3'h5} ^ {8{m}};
    endfunction

    always #4 clk_in = ~clk_in;

    // Cycle ceiling and pulse counters
    always @(posedge clk_in) begin
        cycles++;
        if (host_rd === 1'b1) begin
            rd_seen++;
        end
        if (host_wr === 1'b1) begin
            wr_seen++;
        end
        if (cycles == 6000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // Write every register in one style, read back in the other
    initial begin
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 32; i++) begin
                mode = m[0];
                access(1'b1, i[4:3], i[2:0], pat(m[0], i[4:3], i[2:0]));
            end
            for (int i = 0; i < 32; i++) begin
                mode = ~m[0];
                rd(i[4:3], i[2:0], pat(m[0], i[4:3], i[2:0]));
            end
        end
        loc_chan = 2'h2;
        loc_addr = 3'h5;
        loc_wdata = 8'hC3;
        loc_we = 1'b1;
        @(negedge clk_in);
        loc_we = 1'b0;
        mode = 1'b1;
        rd(2'h2, 3'h5, 8'hC3);
        repeat (12) @(negedge clk_in);
        chk("idle bus", 8'hFF, bus.data_bus);
        chk("dev oe", 8'h00, {7'h00, bus.dev_data_oe});
        chk("reads", 8'h41, rd_seen[7:0]);
        chk("writes", 8'h40, wr_seen[7:0]);
        report_and_stop();
    end
endmodule

`default_nettype wire
